// ### sar_adc_pkg.sv
// constants, types and helper functions for the converter control block
// assumes one 200 MHz system clock and an 8-bit special-function register port
// Function
// - converter clock is system clock divided by 32, 16, 8 or 4 by select
// - writing one to the start bit converts; hardware clears it on finish
// - software may write zero to the start bit to clear it
// - end of conversion sets the done flag and, when enabled, requests interrupt
// - done flag clears on written zero or start; other flag bits unaffected
// - one conversion takes 50 converter clocks: sample-hold plus two per bit
// - result bits 11 to 4 fill the whole high result register
// - low result register holds bits 3 to 0 in its upper nibble
// - four-bit input select routes inputs, bandgap, quarter supply; 1010 reserved
// - two-bit reference select: supply, 2.5 V, 3 V or 4 V
// - selecting the bandgap input switches the bandgap generator on automatically, except in stop
// - force bit keeps bandgap on always, also idle, but off in stop
package sar_adc_pkg;

   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_OPTIONS   = 8'h94;
   localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h95;
   localparam logic [7:0] ADDR_RES_LOW   = 8'hAA;
   localparam logic [7:0] ADDR_RES_HIGH  = 8'hAB;
   localparam logic [7:0] ADDR_INPUT_MUX = 8'hAE;
   localparam logic [7:0] ADDR_MISC      = 8'hF8;

   // ----------------------------------------------------------------
   // field positions, masks and reset values
   // ----------------------------------------------------------------
   localparam int unsigned DIV_SEL_LSB   = 2;
   localparam int unsigned DONE_FLAG_BIT = 4;
   localparam int unsigned START_BIT     = 4;
   localparam int unsigned INPUT_SEL_LSB = 4;
   localparam int unsigned REF_SEL_LSB   = 2;
   localparam int unsigned BG_FORCE_BIT  = 1;

   localparam logic [7:0] OPTIONS_MASK  = 8'hBF;
   localparam logic [7:0] MISC_MASK     = 8'hEF;
   localparam logic [7:0] OPTIONS_RST   = 8'h00;
   localparam logic [7:0] MISC_RST      = 8'h00;
   localparam logic [3:0] INPUT_SEL_RST = 4'hF;
   localparam logic [1:0] REF_SEL_RST   = 2'h0;
   localparam logic       BG_FORCE_RST  = 1'b0;
   localparam logic [11:0] RESULT_RST   = 12'h000;

   // ----------------------------------------------------------------
   // input and reference codes
   // ----------------------------------------------------------------
   localparam logic [3:0] SEL_RESERVED      = 4'hA;
   localparam logic [3:0] SEL_BANDGAP       = 4'hB;
   localparam logic [3:0] SEL_QUARTER_SUPPLY = 4'hF;
   localparam logic [1:0] REF_SUPPLY        = 2'h0;
   localparam logic [1:0] REF_2V5           = 2'h1;
   localparam logic [1:0] REF_3V            = 2'h2;
   localparam logic [1:0] REF_4V            = 2'h3;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned SYS_CLK_HZ      = 200_000_000;
   localparam int unsigned MAX_CONV_CLK_HZ = 1_000_000;
   localparam int unsigned RESULT_BITS     = 12;
   localparam logic [5:0]  CONV_TICKS      = 6'h32;
   localparam logic [5:0]  SAMPLE_TICKS    = CONV_TICKS - 6'(2 * RESULT_BITS);
   localparam logic [3:0]  MSB_POS         = 4'(RESULT_BITS - 1);

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAMPLE, SEQ_RESOLVE} seq_state_t;

   // last count of the converter clock divider for each select code
   function automatic logic [4:0] div_last(input logic [1:0] sel);
      case (sel)
         2'h0:    div_last = 5'h1F;
         2'h1:    div_last = 5'h0F;
         2'h2:    div_last = 5'h07;
         default: div_last = 5'h03;
      endcase
   endfunction

endpackage

// ### conv_if.sv
// carrier between the register block and the conversion sequencer
// assumes both ends sit on the same system clock
`timescale 1ns/1ps
interface conv_if;
   logic        run;
   logic        start;
   logic [1:0]  divSel;
   logic        cmp;
   logic        busy;
   logic        sampling;
   logic        done;
   logic [11:0] result;
   logic [11:0] dac;

   modport ctrl (output run, start, divSel, cmp, input busy, sampling, done, result, dac);
   modport seq  (input run, start, divSel, cmp, output busy, sampling, done, result, dac);
endinterface

// ### conv_sequencer.sv
// converter clock divider and successive-approximation sequencer
// assumes start is a one-cycle pulse and cmp is already synchronised
`timescale 1ns/1ps
module conv_sequencer
   import sar_adc_pkg::*;
(
   input  wire logic clock,
   input  wire logic nrst,
   conv_if.seq       c
);
   seq_state_t  state_q;
   logic [4:0]  divCnt_q;
   logic [5:0]  tickIdx_q;
   logic [11:0] code_q;
   logic [11:0] result_q;
   logic        done_q;
   logic        sampling_q;
   logic        tick;
   logic [5:0]  phase;
   logic [3:0]  bitPos;
   logic        lastTick;

   assign tick     = (state_q != SEQ_IDLE) && (divCnt_q == div_last(c.divSel));
   assign phase    = tickIdx_q - SAMPLE_TICKS;
   assign bitPos   = MSB_POS - {1'b0, phase[3:1]} - {phase[4], 3'h0};
   assign lastTick = tick && (tickIdx_q == CONV_TICKS - 6'h01) && c.run;

   // ----------------------------------------------------------------
   // converter clock divider
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         divCnt_q <= 5'h00;
      end else if (c.start || state_q == SEQ_IDLE || tick) begin
         divCnt_q <= 5'h00;
      end else begin
         divCnt_q <= divCnt_q + 5'h01;
      end
   end

   // ----------------------------------------------------------------
   // conversion sequence
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_q    <= SEQ_IDLE;
         tickIdx_q  <= 6'h00;
         sampling_q <= 1'b0;
      end else if (c.start) begin
         state_q    <= SEQ_SAMPLE;
         tickIdx_q  <= 6'h00;
         sampling_q <= 1'b1;
      end else if (!c.run) begin
         state_q    <= SEQ_IDLE;
         sampling_q <= 1'b0;
      end else if (tick) begin
         tickIdx_q <= tickIdx_q + 6'h01;
         case (state_q)
            SEQ_SAMPLE: begin
               if (tickIdx_q == SAMPLE_TICKS - 6'h01) begin
                  state_q    <= SEQ_RESOLVE;
                  sampling_q <= 1'b0;
               end
            end
            SEQ_RESOLVE: begin
               if (lastTick) begin
                  state_q <= SEQ_IDLE;
               end
            end
            default: state_q <= SEQ_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // approximation register: trial on even phase, decide on odd
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         code_q <= RESULT_RST;
      end else if (c.start) begin
         code_q <= RESULT_RST;
      end else if (tick && state_q == SEQ_RESOLVE && c.run) begin
         if (!phase[0]) begin
            code_q[bitPos] <= 1'b1;
         end else if (!c.cmp) begin
            code_q[bitPos] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         done_q   <= 1'b0;
         result_q <= RESULT_RST;
      end else begin
         done_q <= lastTick && !c.start;
         if (lastTick) begin
            result_q <= {code_q[11:1], c.cmp};
         end
      end
   end

   assign c.busy     = (state_q != SEQ_IDLE);
   assign c.sampling = sampling_q;
   assign c.done     = done_q;
   assign c.result   = result_q;
   assign c.dac      = code_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [4:0] gapCnt_q;
   logic [5:0] tickCnt_q;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         gapCnt_q  <= 5'h00;
         tickCnt_q <= 6'h00;
      end else begin
         gapCnt_q  <= (c.start || tick) ? 5'h00 : gapCnt_q + 5'h01;
         tickCnt_q <= c.start ? 6'h00 : (tick ? tickCnt_q + 6'h01 : tickCnt_q);
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);

   property p_div_gap;
      tick && $stable(c.divSel) |-> gapCnt_q == 5'((32 >> c.divSel) - 1);
   endproperty
   a_div_gap: assert property (p_div_gap) else $error("converter clock period wrong");

   property p_conv_len;
      c.done |-> tickCnt_q == CONV_TICKS;
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

   property p_msb_first;
      tick && state_q == SEQ_RESOLVE && tickIdx_q == SAMPLE_TICKS && c.run && !c.start
         |=> code_q == 12'h800;
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("first trial not on msb");

   c_full_conv: cover property (c.start && c.divSel == 2'h3 ##[1:300] c.done);
endmodule // conv_sequencer

// ### sar_adc_control.sv
// register side of the converter control: special-function registers,
// start/done handshake, input, reference and bandgap control
// assumes a single-cycle register port on the system clock and an
// asynchronous comparator pin from the analog converter
`timescale 1ns/1ps
module sar_adc_control
   import sar_adc_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic [7:0]  sfrAddr,
   input  wire logic        sfrWrite,
   input  wire logic        sfrRead,
   input  wire logic [7:0]  sfrWData,
   output logic      [7:0]  sfrRData,
   input  wire logic        adcIntEnable,
   input  wire logic        stopMode,
   input  wire logic        cmpIn,
   output logic      [3:0]  inputSelect,
   output logic      [1:0]  referenceSelect,
   output logic             bandgapEn,
   output logic             sampleHold,
   output logic      [11:0] dacCode,
   output logic             adcIrq
);
   import sar_adc_pkg::*;

   conv_if conv ();

   logic [7:0]  options_q;
   logic [7:0]  misc_q;
   logic        convStartBit_q;
   logic        startPulse_q;
   logic        convDoneFlag_q;
   logic [7:0]  resultHighByte_q;
   logic [3:0]  resultLowNibble_q;
   logic [3:0]  inputSel_q;
   logic [1:0]  refSel_q;
   logic        bandgapForceOn_q;
   logic        bandgapEn_q;
   logic        irq_q;
   logic [7:0]  rdata_q;
   logic        cmpMeta_q;
   logic        cmpSync_q;
   logic        wrOptions;
   logic        wrFlags;
   logic        wrMux;
   logic        wrMisc;
   logic        startWrite;
   logic        startNow;
   logic        stopWrite;

   assign wrOptions  = sfrWrite && sfrAddr == ADDR_OPTIONS;
   assign wrFlags    = sfrWrite && sfrAddr == ADDR_IRQ_FLAGS;
   assign wrMux      = sfrWrite && sfrAddr == ADDR_INPUT_MUX;
   assign wrMisc     = sfrWrite && sfrAddr == ADDR_MISC;
   assign startWrite = wrMisc && sfrWData[START_BIT];
   assign startNow   = startWrite && !convStartBit_q;
   assign stopWrite  = wrMisc && !sfrWData[START_BIT];

   // ----------------------------------------------------------------
   // comparator pin synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cmpMeta_q <= 1'b0;
         cmpSync_q <= 1'b0;
      end else begin
         cmpMeta_q <= cmpIn;
         cmpSync_q <= cmpMeta_q;
      end
   end

   // ----------------------------------------------------------------
   // plain read/write registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         options_q <= OPTIONS_RST;
      end else if (wrOptions) begin
         options_q <= sfrWData & OPTIONS_MASK;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         misc_q <= MISC_RST;
      end else if (wrMisc) begin
         misc_q <= sfrWData & MISC_MASK;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         inputSel_q       <= INPUT_SEL_RST;
         refSel_q         <= REF_SEL_RST;
         bandgapForceOn_q <= BG_FORCE_RST;
      end else if (wrMux) begin
         inputSel_q       <= sfrWData[INPUT_SEL_LSB +: 4];
         refSel_q         <= sfrWData[REF_SEL_LSB +: 2];
         bandgapForceOn_q <= sfrWData[BG_FORCE_BIT];
      end
   end

   // ----------------------------------------------------------------
   // start bit: software sets or clears, hardware clears at the end
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         convStartBit_q <= 1'b0;
         startPulse_q   <= 1'b0;
      end else begin
         startPulse_q <= startNow;
         if (startNow) begin
            convStartBit_q <= 1'b1;
         end else if (stopWrite) begin
            convStartBit_q <= 1'b0;
         end else if (conv.done) begin
            convStartBit_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // done flag: hardware set wins over any clear in the same cycle
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         convDoneFlag_q <= 1'b0;
      end else if (conv.done) begin
         convDoneFlag_q <= 1'b1;
      end else if ((wrFlags && !sfrWData[DONE_FLAG_BIT]) || startWrite) begin
         convDoneFlag_q <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= convDoneFlag_q && adcIntEnable;
      end
   end

   // ----------------------------------------------------------------
   // result registers, loaded only at the end of a conversion
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         resultHighByte_q  <= RESULT_RST[11:4];
         resultLowNibble_q <= RESULT_RST[3:0];
      end else if (conv.done) begin
         resultHighByte_q  <= conv.result[11:4];
         resultLowNibble_q <= conv.result[3:0];
      end
   end

   // ----------------------------------------------------------------
   // bandgap enable: automatic on select, or forced, never in stop
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bandgapEn_q <= 1'b0;
      end else begin
         bandgapEn_q <= !stopMode && (bandgapForceOn_q || inputSel_q == SEL_BANDGAP);
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 8'h00;
      end else if (sfrRead) begin
         case (sfrAddr)
            ADDR_OPTIONS:   rdata_q <= options_q;
            ADDR_IRQ_FLAGS: rdata_q <= {3'h0, convDoneFlag_q, 4'h0};
            ADDR_RES_LOW:   rdata_q <= {resultLowNibble_q, 4'h0};
            ADDR_RES_HIGH:  rdata_q <= resultHighByte_q;
            ADDR_INPUT_MUX: rdata_q <= {inputSel_q, refSel_q, bandgapForceOn_q, 1'b0};
            ADDR_MISC:      rdata_q <= {misc_q[7:5], convStartBit_q, misc_q[3:0]};
            default:        rdata_q <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // sequencer and outputs
   // ----------------------------------------------------------------
   assign conv.run    = convStartBit_q;
   assign conv.start  = startPulse_q;
   assign conv.divSel = options_q[DIV_SEL_LSB +: 2];
   assign conv.cmp    = cmpSync_q;

   conv_sequencer u_seq (
      .clock (clock),
      .nrst  (nrst),
      .c     (conv.seq)
   );

   assign sfrRData        = rdata_q;
   assign inputSelect     = inputSel_q;
   assign referenceSelect = refSel_q;
   assign bandgapEn       = bandgapEn_q;
   assign sampleHold      = conv.sampling;
   assign dacCode         = conv.dac;
   assign adcIrq          = irq_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);

   property p_start_runs;
      startNow |=> convStartBit_q ##1 conv.busy;
   endproperty
   a_start_runs: assert property (p_start_runs) else $error("start did not begin");

   property p_done_clears_start;
      conv.done && !startNow |=> !convStartBit_q;
   endproperty
   a_done_clears_start: assert property (p_done_clears_start) else $error("start bit stuck");

   property p_sw_clear;
      stopWrite |=> !convStartBit_q ##1 !conv.busy;
   endproperty
   a_sw_clear: assert property (p_sw_clear) else $error("start bit not cleared");

   property p_flag_irq;
      conv.done |=> convDoneFlag_q ##1 (adcIrq == $past(adcIntEnable));
   endproperty
   a_flag_irq: assert property (p_flag_irq) else $error("done flag or request missing");

   property p_flag_clear;
      wrFlags && !sfrWData[DONE_FLAG_BIT] && !conv.done |=> !convDoneFlag_q;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("done flag not cleared");

   property p_result_load;
      conv.done |=> resultHighByte_q == $past(conv.result[11:4])
                    && resultLowNibble_q == $past(conv.result[3:0]);
   endproperty
   a_result_load: assert property (p_result_load) else $error("result not loaded");

   property p_result_hold;
      !conv.done |=> $stable(resultHighByte_q) && $stable(resultLowNibble_q);
   endproperty
   a_result_hold: assert property (p_result_hold) else $error("result changed early");

   property p_bg_auto;
      inputSel_q == SEL_BANDGAP && !stopMode |=> bandgapEn;
   endproperty
   a_bg_auto: assert property (p_bg_auto) else $error("bandgap not enabled");

   property p_bg_stop;
      stopMode |=> !bandgapEn;
   endproperty
   a_bg_stop: assert property (p_bg_stop) else $error("bandgap on in stop");

   property p_force_on;
      bandgapForceOn_q && !stopMode |=> bandgapEn;
   endproperty
   a_force_on: assert property (p_force_on) else $error("forced bandgap off");

   property p_bg_auto_off;
      !bandgapForceOn_q && inputSel_q != SEL_BANDGAP |=> !bandgapEn;
   endproperty
   a_bg_auto_off: assert property (p_bg_auto_off) else $error("bandgap left on");

   property p_options_write;
      wrOptions |=> conv.divSel == $past(sfrWData[DIV_SEL_LSB +: 2]);
   endproperty
   a_options_write: assert property (p_options_write) else $error("divider select lost");

   property p_flag_start_clear;
      startWrite && !conv.done |=> !convDoneFlag_q;
   endproperty
   a_flag_start_clear: assert property (p_flag_start_clear) else $error("flag kept on start");

   property p_flag_keep;
      wrFlags && sfrWData[DONE_FLAG_BIT] && convDoneFlag_q |=> convDoneFlag_q;
   endproperty
   a_flag_keep: assert property (p_flag_keep) else $error("flag cleared by one");

   property p_irq_off;
      !adcIntEnable |=> !adcIrq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("request while disabled");

   property p_low_pad;
      sfrRead && sfrAddr == ADDR_RES_LOW |=> sfrRData[3:0] == 4'h0;
   endproperty
   a_low_pad: assert property (p_low_pad) else $error("low result padding wrong");

   property p_start_ignored;
      startWrite && convStartBit_q |=> !startPulse_q;
   endproperty
   a_start_ignored: assert property (p_start_ignored) else $error("running conversion restarted");

   c_done_irq: cover property (conv.done && adcIntEnable ##2 adcIrq);
   c_abort:    cover property (conv.busy && stopWrite);
   c_restart:  cover property (conv.done ##[1:20] startNow);
   c_bg_force: cover property (bandgapForceOn_q && inputSel_q != SEL_BANDGAP && bandgapEn);
endmodule // sar_adc_control

// ### sar_comparator_model.sv
// behavioural comparator of the analog converter facing the trial code
// assumes the control block samples cmpIn through its own synchroniser
`timescale 1ns/1ps
module sar_comparator_model #(
   parameter int unsigned RESP_NS = 2
) (
   input  wire logic [11:0] dacCode,
   input  wire logic [11:0] level,
   output wire logic        cmpIn
);
   // keep the trial bit while the input is not below the trial code
   assign #RESP_NS cmpIn = (level >= dacCode);
endmodule // sar_comparator_model

// ### sar_adc_control_test.sv
// self-checking bench for the converter control block
// assumes the comparator model sits on the analog side
`timescale 1ns/1ps
module sar_adc_control_test;
   import sar_adc_pkg::*;
   logic        clock, nrst, sfrWrite, sfrRead, adcIntEnable, stopMode, rdSeen;
   logic [7:0]  sfrAddr, sfrWData, sfrRData;
   logic [3:0]  inputSelect;
   logic [1:0]  referenceSelect, r;
   logic        bandgapEn, sampleHold, adcIrq, f;
   wire         cmpIn;
   logic [11:0] dacCode, level, last;
   logic [7:0]  expQ[$];
   int          failCount, testsRun, cycles;
   localparam logic [7:0] RA[7] = '{8'h94, 8'h95, 8'hAA, 8'hAB, 8'hAE, 8'hF8, 8'h96};
   localparam logic [7:0] RV[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hF0, 8'h00, 8'h00};

   sar_adc_control uut (.clock(clock), .nrst(nrst), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
      .sfrRead(sfrRead), .sfrWData(sfrWData), .sfrRData(sfrRData),
      .adcIntEnable(adcIntEnable), .stopMode(stopMode), .cmpIn(cmpIn),
      .inputSelect(inputSelect), .referenceSelect(referenceSelect), .bandgapEn(bandgapEn),
      .sampleHold(sampleHold), .dacCode(dacCode), .adcIrq(adcIrq));
   sar_comparator_model #(.RESP_NS(2)) model (.dacCode(dacCode), .level(level), .cmpIn(cmpIn));

   always #2.5 clock = ~clock;

   task automatic cmpVal(input logic [11:0] got, input logic [11:0] exp);
      testsRun++;
      if (got !== exp) begin
         failCount++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic printVerdict();
      $display("comparisons %0d mismatches %0d", testsRun, failCount);
      if (failCount == 0 && testsRun > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      sfrAddr <= a;
      sfrWData <= d;
      sfrWrite <= 1'b1;
      @(posedge clock);
      sfrWrite <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      expQ.push_back(e);
      @(posedge clock);
      sfrAddr <= a;
      sfrRead <= 1'b1;
      @(posedge clock);
      sfrRead <= 1'b0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic convert(input logic [1:0] div);
      int cnt;
      int sh;
      logic [7:0] opt;
      cnt = 0;
      sh = 0;
      opt = 8'($urandom);
      opt[3:2] = div;
      level = 12'($urandom);
      wr(ADDR_IRQ_FLAGS, 8'hEF);
      wr(ADDR_OPTIONS, opt);
      rd(ADDR_OPTIONS, opt & OPTIONS_MASK);
      wr(ADDR_MISC, 8'h10);
      while (adcIrq !== 1'b1 && cnt < 2000) begin
         @(posedge clock);
         #1;
         cnt++;
         sh += sampleHold;
      end
      cmpVal(12'(cnt), 12'(CONV_TICKS * (32 >> div) + 3));
      cmpVal(12'(sh), 12'((CONV_TICKS - 2 * RESULT_BITS) * (32 >> div)));
      cmpVal(dacCode, level);
      rd(ADDR_RES_HIGH, level[11:4]);
      rd(ADDR_RES_LOW, {level[3:0], 4'h0});
      rd(ADDR_IRQ_FLAGS, 8'h10);
      rd(ADDR_MISC, 8'h00);
   endtask

   // ------------------------------------------------------------
   // read data monitor and hang guard
   // ------------------------------------------------------------
   always @(posedge clock) begin
      rdSeen <= sfrRead;
      cycles++;
      if (cycles > 20000) begin
         failCount++;
         printVerdict();
      end
   end

   always @(negedge clock) begin
      if (rdSeen === 1'b1 && expQ.size() > 0)
         cmpVal({4'h0, sfrRData}, {4'h0, expQ.pop_front()});
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      clock = 1'b0;
      nrst = 1'b0;
      {sfrWrite, sfrRead, stopMode} = 3'h0;
      {sfrAddr, sfrWData} = 16'h0000;
      adcIntEnable = 1'b1;
      level = 12'h000;
      void'($urandom(2452));
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      foreach (RA[i]) rd(RA[i], RV[i]);
      for (int c = 0; c < 16; c++) begin
         r = 2'($urandom);
         f = 1'($urandom);
         wr(ADDR_INPUT_MUX, {4'(c), r, f, 1'b1});
         settle(2);
         cmpVal(12'(inputSelect), 12'(c));
         cmpVal(12'(referenceSelect), 12'(r));
         cmpVal(12'(bandgapEn), 12'((c == 11) || f));
         rd(ADDR_INPUT_MUX, {4'(c), r, f, 1'b0});
      end
      wr(ADDR_INPUT_MUX, 8'h02);
      @(posedge clock) stopMode <= 1'b1;
      settle(2);
      cmpVal(12'(bandgapEn), 12'h000);
      @(posedge clock) stopMode <= 1'b0;
      settle(2);
      cmpVal(12'(bandgapEn), 12'h001);
      wr(ADDR_RES_HIGH, 8'h5A);
      rd(ADDR_RES_HIGH, 8'h00);
      for (int v = 0; v < 4; v++) convert(2'(v));
      wr(ADDR_IRQ_FLAGS, 8'hFF);
      rd(ADDR_IRQ_FLAGS, 8'h10);
      @(posedge clock) adcIntEnable <= 1'b0;
      settle(2);
      cmpVal(12'(adcIrq), 12'h000);
      @(posedge clock) adcIntEnable <= 1'b1;
      settle(2);
      cmpVal(12'(adcIrq), 12'h001);
      last = level;
      level = ~last;
      wr(ADDR_MISC, 8'h10);
      wr(ADDR_MISC, 8'h10);
      rd(ADDR_IRQ_FLAGS, 8'h00);
      wr(ADDR_MISC, 8'h00);
      rd(ADDR_MISC, 8'h00);
      settle(300);
      rd(ADDR_IRQ_FLAGS, 8'h00);
      rd(ADDR_RES_HIGH, last[11:4]);
      settle(4);
      printVerdict();
   end
endmodule // sar_adc_control_test
